// ===== bench/handset_power_sequencer_bench.sv
// Self-checking bench for the handset power sequencer.
// Assumes shortened timers and a stepwise regulator ramp model.
`timescale 1ns/10ps
`default_nettype none
module handset_power_sequencer_bench
  import hps_pkg::*;
;
  localparam int DB = 20, LG = 30, RD = 40, HW = 100, RAMP = 8;
  logic       core_clk = 1'b0;
  logic       rst_b    = 1'b0;
  logic       key      = 1'b0;
  logic       chgN     = 1'b1;
  logic       dropReq  = 1'b0;
  logic       droop    = 1'b0;
  logic [1:0] mode     = 2'h0;
  logic       hold, reg1En, reg2En, rstN, irqOut, irqOe, seen;
  int         lvl1 = 0, lvl2 = 0, n_mismatch = 0, n_checks = 0;
  always #20 core_clk = ~core_clk;
  // ----------------------------------------
  // Regulator ramp model and host
  // ----------------------------------------
  always @(negedge core_clk) begin
    lvl1 <= (reg1En && !droop) ? (lvl1 < RAMP ? lvl1 + 1 : lvl1) : (lvl1 > 0 ? lvl1 - 1 : 0);
    lvl2 <= reg2En ? (lvl2 < RAMP ? lvl2 + 1 : lvl2) : (lvl2 > 0 ? lvl2 - 1 : 0);
  end
  hps_host_model #(.SLOW(HW - 15)) u_host (.core_clk(core_clk), .rst_b(rst_b),
    .hostReset_n(rstN), .mode(mode), .dropReq(dropReq), .host_power_hold(hold));
  hps_sequencer #(.DEBOUNCE_CYCLES(DB), .LONG_GAP_CYCLES(LG), .RST_DELAY_CYCLES(RD),
    .HOLD_WINDOW_CYCLES(HW), .LONG_GAP(1'b0)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .power_key_in(key), .charger_detect_n(chgN),
    .host_power_hold(hold), .firstRegAboveHi(lvl1 == RAMP),
    .firstRegBelowLo(lvl1 <= RAMP - 2), .secondRegAboveHi(lvl2 == RAMP),
    .secondRegBelowLo(lvl2 <= RAMP - 2), .first_regulator(reg1En),
    .second_regulator(reg2En), .hostReset_n(rstN), .keyIrqOut(irqOut),
    .keyIrqOe(irqOe), .chargerSeen(seen));
  // ----------------------------------------
  // Comparison and wait helpers
  // ----------------------------------------
  function automatic logic sig(input int s);
    case (s)
      0: return reg1En;
      1: return reg2En;
      2: return rstN;
      default: return irqOe;
    endcase
  endfunction : sig
  task automatic chk(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk
  // Sync stages make the design's latency uncertain by up to three cycles
  task automatic near(input string nm, input int exp, input int got);
    n_checks++;
    if (got < exp - 3 || got > exp + 3) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : near
  task automatic cycles(input int c);
    repeat (c) @(negedge core_clk);
  endtask : cycles
  task automatic waitFor(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk($sformatf("output%0d", s), v, sig(s));
  endtask : waitFor
  task automatic pressKey();
    key = 1'b1;
    cycles($urandom % (DB - 4) + 2);
    key = 1'b0;
    cycles(1);
    chk("noEarlyStart", 1'b0, reg1En);
    key = 1'b1;
  endtask : pressKey
  task automatic powerUp(input logic viaKey);
    int n;
    waitFor(0, 1'b1, DB + 20, n);
    near("startDelay", DB + 3, n);
    key = 1'b0;
    chk("irqAtStart", viaKey, irqOe);
    chk("irqPinLow", 1'b0, irqOut);
    waitFor(1, 1'b1, SHORT_GAP_CYC + 40, n);
    near("gapDelay", RAMP + 3 + SHORT_GAP_CYC, n);
    chk("rstHeld", 1'b0, rstN);
    waitFor(2, 1'b1, RD + 40, n);
    near("rstDelay", RAMP + 3 + RD, n);
    chk("irqAtRelease", viaKey, irqOe);
  endtask : powerUp
  task automatic powerDown(input int extra);
    int n;
    waitFor(1, 1'b0, RD + 40, n);
    near("reg2OffDelay", RD + extra, n);
    chk("irqOff", 1'b0, irqOe);
    waitFor(0, 1'b0, SHORT_GAP_CYC + 40, n);
    near("reg1OffDelay", 5 + SHORT_GAP_CYC, n);
    chk("rstLow", 1'b0, rstN);
  endtask : powerDown
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int n;
    void'($urandom(63663));
    cycles(16);
    rst_b = 1'b1;
    mode = 2'h1;
    pressKey();
    powerUp(1'b1);
    waitFor(3, 1'b0, HW, n);
    near("lateHoldIrq", HW - 11, n);
    cycles(HW);
    chk("stayOn", 1'b1, rstN);
    key = 1'b1;
    cycles(DB + 10);
    key = 1'b0;
    cycles(5);
    chk("keyWhileOn", 1'b1, reg2En);
    chk("irqQuiet", 1'b0, irqOe);
    chgN = 1'b0;
    cycles(DB + 10);
    chk("chargerSeen", 1'b1, seen);
    chk("rstKept", 1'b1, rstN);
    chgN = 1'b1;
    cycles(DB + 10);
    chk("chargerGone", 1'b0, seen);
    dropReq = 1'b1;
    waitFor(2, 1'b0, 20, n);
    near("holdToReset", 4, n);
    powerDown(0);
    dropReq = 1'b0;
    mode = 2'h2;
    pressKey();
    powerUp(1'b1);
    waitFor(3, 1'b0, HW + 10, n);
    near("holdWindow", HW, n);
    chk("windowReset", 1'b0, rstN);
    powerDown(0);
    chgN = 1'b0;
    powerUp(1'b0);
    cycles(HW + 20);
    chk("chargerKeepsRst", 1'b1, rstN);
    chk("chargerKeepsReg2", 1'b1, reg2En);
    chk("chargerNoIrq", 1'b0, irqOe);
    chgN = 1'b1;
    waitFor(2, 1'b0, DB + 20, n);
    near("chargerOffToRst", DB + 4, n);
    powerDown(0);
    mode = 2'h0;
    pressKey();
    powerUp(1'b1);
    cycles(20);
    droop = 1'b1;
    waitFor(2, 1'b0, RAMP + 10, n);
    near("droopToReset", 6, n);
    powerDown(3);
    droop = 1'b0;
    final_report();
  end
  initial begin
    cycles(60000);
    n_mismatch++;
    final_report();
  end
endmodule : handset_power_sequencer_bench
`default_nettype wire

// ===== bench/hps_host_model.sv
// Host processor model that drives the hold line.
// Assumes hostReset_n from the sequencer and a mode set by the bench.
`timescale 1ns/10ps
`default_nettype none
module hps_host_model #(
  parameter int SLOW = 85
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       hostReset_n,
  input  wire logic [1:0] mode,
  input  wire logic       dropReq,
  output var  logic       host_power_hold
);
  int cnt_q;
  // Mode 0 answers fast, 1 late in the window, 2 never holds power
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_power_hold <= 1'b0;
      cnt_q           <= 0;
    end else if (!hostReset_n || dropReq) begin
      host_power_hold <= 1'b0;
      cnt_q           <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
      if (mode != 2'h2 && cnt_q == (mode == 2'h0 ? 5 : SLOW)) begin
        host_power_hold <= 1'b1;
      end
    end
  end
endmodule : hps_host_model
`default_nettype wire

// ===== bench/hps_sequencer_chk.sv
// Assertion checker for the handset power sequencer.
// Assumes it is bound to hps_sequencer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module hps_sequencer_chk
  import hps_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES    = 20,
  parameter int unsigned LONG_GAP_CYCLES    = 30,
  parameter int unsigned RST_DELAY_CYCLES   = 40,
  parameter int unsigned HOLD_WINDOW_CYCLES = 100,
  parameter bit          LONG_GAP           = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic power_key_in,
  input wire logic charger_detect_n,
  input wire logic host_power_hold,
  input wire logic firstRegAboveHi,
  input wire logic firstRegBelowLo,
  input wire logic secondRegAboveHi,
  input wire logic secondRegBelowLo,
  input wire logic first_regulator,
  input wire logic second_regulator,
  input wire logic hostReset_n,
  input wire logic keyIrqOut,
  input wire logic keyIrqOe,
  input wire logic chargerSeen
);
  localparam int GAP = LONG_GAP ? LONG_GAP_CYCLES : SHORT_GAP_CYC;
  int r1On_q, r2On_q, r2Off_q, rstLow_q, hw_q, chgHi_q;
  function automatic int inc(input int v);
    return (v < 1000000) ? v + 1 : v;
  endfunction : inc
  // ----------------------------------------
  // Elapsed time since the watched outputs and the charger input changed
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r1On_q   <= 0;
      r2On_q   <= 0;
      r2Off_q  <= 0;
      rstLow_q <= 0;
      hw_q     <= 0;
      chgHi_q  <= 0;
    end else begin
      r1On_q   <= first_regulator ? inc(r1On_q) : 0;
      r2On_q   <= second_regulator ? inc(r2On_q) : 0;
      r2Off_q  <= second_regulator ? 0 : inc(r2Off_q);
      rstLow_q <= hostReset_n ? 0 : inc(rstLow_q);
      hw_q     <= (keyIrqOe && hostReset_n) ? inc(hw_q) : 0;
      chgHi_q  <= charger_detect_n ? inc(chgHi_q) : 0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_reg2_gap;
    $rose(second_regulator) |-> first_regulator && r1On_q >= GAP;
  endproperty
  a_reg2_gap: assert property (p_reg2_gap) else $error("second enable early");
  property p_rst_release;
    $rose(hostReset_n) |-> second_regulator && r2On_q >= RST_DELAY_CYCLES;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset release early");
  property p_reg2_off;
    $fell(second_regulator) |-> !hostReset_n && rstLow_q >= RST_DELAY_CYCLES;
  endproperty
  a_reg2_off: assert property (p_reg2_off) else $error("second disable early");
  property p_reg1_off;
    $fell(first_regulator) |-> !second_regulator && r2Off_q >= GAP;
  endproperty
  a_reg1_off: assert property (p_reg1_off) else $error("first disable early");
  property p_fault;
    hostReset_n && ((firstRegBelowLo && !firstRegAboveHi) ||
      (secondRegBelowLo && !secondRegAboveHi)) |-> ##[1:6] !hostReset_n;
  endproperty
  a_fault: assert property (p_fault) else $error("no reset on regulator droop");
  property p_irq_drive;
    keyIrqOe |-> !keyIrqOut && first_regulator;
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt drive wrong");
  property p_charger_seen;
    $rose(chargerSeen) |-> $stable(first_regulator) && $stable(second_regulator)
      && $stable(hostReset_n) && $stable(keyIrqOe);
  endproperty
  a_charger_seen: assert property (p_charger_seen) else $error("charger disturbed outputs");
  property p_hold_irq;
    keyIrqOe && host_power_hold |-> ##[1:5] !keyIrqOe;
  endproperty
  a_hold_irq: assert property (p_hold_irq) else $error("hold did not clear interrupt");
  property p_window;
    hw_q <= HOLD_WINDOW_CYCLES + 1;
  endproperty
  a_window: assert property (p_window) else $error("hold window overran");
  property p_hold_low;
    hostReset_n && !keyIrqOe && !host_power_hold && chgHi_q > DEBOUNCE_CYCLES + 4
      |-> ##[1:6] !hostReset_n;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("hold low kept reset high");
  c_key_start: cover property ($rose(keyIrqOe));
  c_charger: cover property ($rose(chargerSeen));
  c_off: cover property ($fell(first_regulator));
endmodule : hps_sequencer_chk
bind hps_sequencer hps_sequencer_chk #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .LONG_GAP_CYCLES(LONG_GAP_CYCLES),
  .RST_DELAY_CYCLES(RST_DELAY_CYCLES), .HOLD_WINDOW_CYCLES(HOLD_WINDOW_CYCLES),
  .LONG_GAP(LONG_GAP)
) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .power_key_in(power_key_in),
  .charger_detect_n(charger_detect_n), .host_power_hold(host_power_hold),
  .firstRegAboveHi(firstRegAboveHi), .firstRegBelowLo(firstRegBelowLo),
  .secondRegAboveHi(secondRegAboveHi), .secondRegBelowLo(secondRegBelowLo),
  .first_regulator(first_regulator), .second_regulator(second_regulator),
  .hostReset_n(hostReset_n), .keyIrqOut(keyIrqOut), .keyIrqOe(keyIrqOe),
  .chargerSeen(chargerSeen)
);
`default_nettype wire

// ===== hw/hps_debounce.sv
// Level debouncer for one synchronised input.
// Assumes rawLevel is already in the core_clk domain.
`timescale 1ns/10ps
`default_nettype none

module hps_debounce
  import hps_pkg::*;
#(
  parameter int unsigned CYCLES = DEBOUNCE_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic rawLevel,
  output var  logic stableLevel
);

  logic [TMR_W-1:0] count_q;
  logic             stable_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Any return to the stable level restarts the count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (rawLevel == stable_q) begin
      count_q <= '0; // R24
    end else begin
      count_q <= count_q + TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stable_q <= 1'b0;
    end else if (rawLevel != stable_q && count_q >= TMR_W'(CYCLES - 1)) begin
      stable_q <= rawLevel; // R1
    end
  end

  assign stableLevel = stable_q;

endmodule : hps_debounce

`default_nettype wire

// ===== hw/hps_pkg.sv
// Constants, reset values and state codes for the handset power sequencer.
// Assumes one core clock at CLK_KHZ; every cycle count is derived from it.
//
// Summary of operation
// (R1) Power key counts as pressed only after staying high for the debounce time.
// (R2) The user must hold the power key longer than the debounce time.
// (R3) A debounced key press while off raises the key interrupt and enables regulator one.
// (R4) After regulator one is good, wait the gap time, then enable regulator two.
// (R5) A build option stretches the gap in both directions to the long gap time.
// (R6) With both regulators good, release host reset after the reset delay.
// (R7) Hold supervision timing starts on the same edge that releases host reset.
// (R8) Hold high inside the window clears the interrupt and keeps power on.
// (R9) Hold still low at window end clears interrupt, asserts reset, powers down.
// (R10) The host must raise hold within the window after reset release.
// (R11) Hold driven low by the host makes the device drive host reset low.
// (R12) In power-down, regulator two is disabled a reset delay after reset falls.
// (R13) Once regulator two is below its low threshold, disable regulator one after the gap.
// (R14) Either regulator below its low threshold while on drives host reset low at once.
// (R15) A further key press while powered never causes power-down by itself.
// (R16) Charger plugged while on is latched; enables, reset and interrupt stay unchanged.
// (R17) Charger plugged while off is debounced, then the normal power-up runs.
// (R18) A charger-started power-up keeps the key interrupt deasserted throughout.
// (R19) While the charger is present both regulators stay on regardless of hold.
// (R20) Charger removed while hold is low drives reset low and powers down in order.
// (R21) The key interrupt is active low with an open-drain drive.
// (R22) Good flags set at the upper threshold and clear at the lower one.
// (R23) The power-up gap is timed from regulator one good to regulator two enable.
// (R24) Debounce restarts on any bounce; all timers run from the one core clock.
`default_nettype none

package hps_pkg;

  localparam int CLK_KHZ        = 25000;
  localparam int TMR_W          = 24;

  localparam int DEBOUNCE_MS    = 32;
  localparam int SHORT_GAP_US   = 125;
  localparam int LONG_GAP_MS    = 10;
  localparam int RST_DELAY_MS   = 20;
  localparam int HOLD_WINDOW_MS = 500;

  // Least times round up, the hold window is a longest time and rounds down
  localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_KHZ;
  localparam int SHORT_GAP_CYC   = (SHORT_GAP_US * CLK_KHZ + 999) / 1000;
  localparam int LONG_GAP_CYC    = LONG_GAP_MS * CLK_KHZ;
  localparam int RST_DELAY_CYC   = RST_DELAY_MS * CLK_KHZ;
  localparam int HOLD_WINDOW_CYC = HOLD_WINDOW_MS * CLK_KHZ;

  // Values after reset
  localparam logic [6:0] SYNC_RESET  = 7'h02;
  localparam logic       HOST_RST_ON = 1'b0;
  localparam logic       IRQ_IDLE    = 1'b0;

  // Synchroniser lane positions
  localparam int LANE_KEY    = 0;
  localparam int LANE_CHG_N  = 1;
  localparam int LANE_HOLD   = 2;
  localparam int LANE_R1_HI  = 3;
  localparam int LANE_R1_LO  = 4;
  localparam int LANE_R2_HI  = 5;
  localparam int LANE_R2_LO  = 6;

  typedef enum logic [11:0] {
    ST_OFF       = 12'h001,
    ST_REG1_UP   = 12'h002,
    ST_GAP_UP    = 12'h004,
    ST_REG2_UP   = 12'h008,
    ST_RST_WAIT  = 12'h010,
    ST_HOLD_WAIT = 12'h020,
    ST_ON        = 12'h040,
    ST_FAULT     = 12'h080,
    ST_DN_RST    = 12'h100,
    ST_DN_REG2   = 12'h200,
    ST_DN_GAP    = 12'h400,
    ST_SPARE     = 12'h800
  } hps_state_t;

endpackage : hps_pkg

`default_nettype wire

// ===== hw/hps_sequencer.sv
// Power-up and power-down sequencer for two regulators and a host processor.
// Assumes pin and comparator inputs are asynchronous; they are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module hps_sequencer
  import hps_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES    = DEBOUNCE_CYC,
  parameter int unsigned LONG_GAP_CYCLES    = LONG_GAP_CYC,
  parameter int unsigned RST_DELAY_CYCLES   = RST_DELAY_CYC,
  parameter int unsigned HOLD_WINDOW_CYCLES = HOLD_WINDOW_CYC,
  parameter bit          LONG_GAP           = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic power_key_in,
  input  wire logic charger_detect_n,
  input  wire logic host_power_hold,
  input  wire logic firstRegAboveHi,
  input  wire logic firstRegBelowLo,
  input  wire logic secondRegAboveHi,
  input  wire logic secondRegBelowLo,
  output var  logic first_regulator,
  output var  logic second_regulator,
  output var  logic hostReset_n,
  output var  logic keyIrqOut,
  output var  logic keyIrqOe,
  output var  logic chargerSeen
);

  // Gap length is fixed at build time and shared by both directions
  localparam int unsigned GAP_CYCLES = LONG_GAP ? LONG_GAP_CYCLES : SHORT_GAP_CYC; // R5

  hps_state_t       state_q;
  hps_state_t       state_d;
  logic [6:0]       syncA_q;
  logic [6:0]       syncB_q;
  logic [TMR_W-1:0] timer_q;
  logic             good1_q;
  logic             good2_q;
  logic             keyStable;
  logic             chgStable;
  logic             keyPrev_q;
  logic             chgPrev_q;
  logic             keyPress;
  logic             chgPlug;
  logic             chgPull;
  logic             holdHigh;
  logic             fault;
  logic             irqSet;
  logic             irqClr;
  logic             reg1_q;
  logic             reg2_q;
  logic             hostRstN_q;
  logic             irq_q;
  logic             chgSeen_q;

  // Timer compare shared by every timed state
  function automatic logic timeUp(
    input logic [TMR_W-1:0] t,
    input int unsigned      lim
  );
    timeUp = (t >= TMR_W'(lim - 1));
  endfunction : timeUp

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= SYNC_RESET;
      syncB_q <= SYNC_RESET;
    end else begin
      syncA_q <= {secondRegBelowLo, secondRegAboveHi, firstRegBelowLo,
                  firstRegAboveHi, host_power_hold, charger_detect_n, power_key_in};
      syncB_q <= syncA_q;
    end
  end

  assign holdHigh = syncB_q[LANE_HOLD];

  // ----------------------------------------------------------------
  // Regulator good flags
  // ----------------------------------------------------------------
  // Hysteresis: set on the upper comparator, cleared only on the lower one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      good1_q <= 1'b0;
    end else if (syncB_q[LANE_R1_HI]) begin
      good1_q <= 1'b1; // R22
    end else if (syncB_q[LANE_R1_LO]) begin
      good1_q <= 1'b0; // R22
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      good2_q <= 1'b0;
    end else if (syncB_q[LANE_R2_HI]) begin
      good2_q <= 1'b1; // R22
    end else if (syncB_q[LANE_R2_LO]) begin
      good2_q <= 1'b0; // R22
    end
  end

  // ----------------------------------------------------------------
  // Debounce and edge detect
  // ----------------------------------------------------------------
  hps_debounce #(
    .CYCLES      (DEBOUNCE_CYCLES)
  ) u_key_db (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .rawLevel    (syncB_q[LANE_KEY]),
    .stableLevel (keyStable)
  );

  // Charger sense is active low; debounced as "charger present"
  hps_debounce #(
    .CYCLES      (DEBOUNCE_CYCLES)
  ) u_chg_db (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .rawLevel    (~syncB_q[LANE_CHG_N]),
    .stableLevel (chgStable)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      keyPrev_q <= 1'b0;
      chgPrev_q <= 1'b0;
    end else begin
      keyPrev_q <= keyStable;
      chgPrev_q <= chgStable;
    end
  end

  assign keyPress = keyStable & ~keyPrev_q;
  assign chgPlug  = chgStable & ~chgPrev_q;
  assign chgPull  = ~chgStable & chgPrev_q;

  // Regulator drop only counts once the host side is being powered
  assign fault = ~(good1_q & good2_q);

  // ----------------------------------------------------------------
  // Sequence timer
  // ----------------------------------------------------------------
  // Restarts on every state change and saturates, so one counter serves all waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= '0;
    end else if (state_d != state_q) begin
      timer_q <= '0; // R24
    end else if (timer_q != {TMR_W{1'b1}}) begin
      timer_q <= timer_q + TMR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    irqSet  = 1'b0;
    irqClr  = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (keyPress) begin
          state_d = ST_REG1_UP; // R3
          irqSet  = 1'b1; // R3
        end else if (chgPlug) begin
          state_d = ST_REG1_UP; // R17 R18
        end
      end
      ST_REG1_UP: begin
        if (good1_q) begin
          state_d = ST_GAP_UP; // R23
        end
      end
      ST_GAP_UP: begin
        if (timeUp(timer_q, GAP_CYCLES)) begin
          state_d = ST_REG2_UP; // R4
        end
      end
      ST_REG2_UP: begin
        if (good1_q && good2_q) begin
          state_d = ST_RST_WAIT; // R6
        end
      end
      ST_RST_WAIT: begin
        if (fault) begin
          state_d = ST_FAULT; // R14
        end else if (timeUp(timer_q, RST_DELAY_CYCLES)) begin
          state_d = ST_HOLD_WAIT; // R6 R7
        end
      end
      ST_HOLD_WAIT: begin
        if (fault) begin
          state_d = ST_FAULT; // R14
          irqClr  = 1'b1;
        end else if (holdHigh) begin
          state_d = ST_ON; // R8
          irqClr  = 1'b1; // R8
        end else if (timeUp(timer_q, HOLD_WINDOW_CYCLES)) begin
          irqClr  = 1'b1; // R9
          if (chgStable) begin
            state_d = ST_ON; // R19
          end else begin
            state_d = ST_DN_RST; // R9
          end
        end
      end
      ST_ON: begin
        // Key presses are not looked at here
        if (fault) begin
          state_d = ST_FAULT; // R14 R15
        end else if (!holdHigh && !chgStable) begin
          state_d = ST_DN_RST; // R11 R19 R20
        end
      end
      ST_FAULT: begin
        // Host reset is held low; shutdown waits for the host to drop hold
        if (!holdHigh && !chgStable) begin
          state_d = ST_DN_RST; // R14 R19
        end
      end
      ST_DN_RST: begin
        if (timeUp(timer_q, RST_DELAY_CYCLES)) begin
          state_d = ST_DN_REG2; // R12
        end
      end
      ST_DN_REG2: begin
        if (!good2_q) begin
          state_d = ST_DN_GAP; // R13
        end
      end
      ST_DN_GAP: begin
        if (timeUp(timer_q, GAP_CYCLES)) begin
          state_d = ST_OFF; // R5 R13
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Enables follow the next state so they switch on the transition edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg1_q <= 1'b0;
    end else begin
      reg1_q <= (state_d != ST_OFF); // R3 R13
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg2_q <= 1'b0;
    end else begin
      reg2_q <= (state_d == ST_REG2_UP) || (state_d == ST_RST_WAIT) ||
                (state_d == ST_HOLD_WAIT) || (state_d == ST_ON) ||
                (state_d == ST_FAULT) || (state_d == ST_DN_RST); // R4 R12 R19
    end
  end

  // Released on entry to hold supervision, the edge the window starts on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostRstN_q <= HOST_RST_ON;
    end else begin
      hostRstN_q <= (state_d == ST_HOLD_WAIT) || (state_d == ST_ON); // R6 R7 R11 R14
    end
  end

  // Set beats clear, as both occur together on a key press in ST_OFF
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= IRQ_IDLE;
    end else if (irqSet) begin
      irq_q <= 1'b1; // R3
    end else if (irqClr || state_q == ST_OFF) begin
      irq_q <= 1'b0; // R8 R9 R18
    end
  end

  // Charger arrival while powered is only latched, nothing else reacts
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chgSeen_q <= 1'b0;
    end else if (chgPlug && state_q != ST_OFF) begin
      chgSeen_q <= 1'b1; // R16
    end else if (chgPull || state_q == ST_OFF) begin
      chgSeen_q <= 1'b0;
    end
  end

  assign first_regulator  = reg1_q;
  assign second_regulator = reg2_q;
  assign hostReset_n      = hostRstN_q;
  // Open drain: pull low only while the interrupt is active
  assign keyIrqOut        = 1'b0; // R21
  assign keyIrqOe         = irq_q; // R21
  assign chargerSeen      = chgSeen_q;

endmodule : hps_sequencer

`default_nettype wire
